// file: hw/spi_flash_pkg.sv
// Shared constants for the serial flash slave and its bus master
package spi_flash_pkg;
	localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_READ_DATA = 8'h03;
	localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] CMD_READ_STATUS = 8'h05;
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] CMD_PAGE_WRITE = 8'h0A;
	localparam int PAGE_BYTES = 256;
	localparam int PAGE_AW = 8;
	localparam int PAGE_SEL_W = 2;
	localparam int MEM_AW = PAGE_AW + PAGE_SEL_W;
	localparam int MEM_BYTES = PAGE_BYTES << PAGE_SEL_W;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam int ST_WIP_BIT = 0;
	localparam int ST_WEL_BIT = 1;
	localparam int ST_BP_LSB = 2;
	localparam logic [2:0] BP_RESET = 3'h0;
	// Synchroniser reset: sck, cs_n, mosi, reset pin, write protect
	localparam logic [4:0] PIN_IDLE = 5'h0B;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PAGE_WRITE_NS = 11_000_000;
	localparam int PAGE_PROGRAM_NS = 800_000;
	localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_NS / CLK_PERIOD_NS;
	localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_NS / CLK_PERIOD_NS;
	localparam int WAIT_W = 24;
	localparam int SCK_PERIOD_NS = 800;
	localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int HALF_W = 3;
	localparam int MAX_DATA_BYTES = 256;
endpackage

// file: hw/spi_flash_if.sv
// Serial link between bus master and flash slave
`timescale 1ns/1ns
interface spi_flash_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic rst_n;
	logic wp_n;
	logic miso_out;
	logic miso_oe;
	logic miso;
	// Released line is held high by the board pull resistor
	assign miso = miso_oe ? miso_out : 1'b1;
	modport master(output sck, output cs_n, output mosi, output rst_n, output wp_n, input miso);
	modport flash(input sck, input cs_n, input mosi, input rst_n, input wp_n, output miso_out, output miso_oe);
endinterface

// file: hw/spi_flash_dev.sv
// Serial flash slave: command decoder, page buffer and internal page write cycle
// What this block does
// - see Output bit changes after serial clock falling edge
// - see Input bit sampled on serial clock rising
// - see Output released while chip select high
// - see Standby only after internal cycle finishes
// - see Commands need a chip select falling edge
// - see Reset pin low: reset, output released
// - see Master avoids reset during internal cycle; the host forwards FLASH_RESET_N_I without checking for a running cycle
// - see Write protect low freezes block protect
// - see Modes 0 and 3 only
// - see Master idles clock at polarity level
// - see Master sends write enable first; the host sends CMD_I as given and leaves write enable to the caller
// - see At most 256 bytes, within one page
// - see Program clears bits; write sets either
// - see Command, three address bytes, data, deselect
// - see Data stored from address low byte
// - see Deselect starts internal page write cycle
// - see Unreceived bytes filled from page
// - see Erase page, then program from buffer
// - see Master sends whole page run at once
// - see Latch cleared on completion, required before
// - see Modifying commands need whole bytes
// - see Write in progress bit readable
`timescale 1ns/1ns
module spi_flash_dev import spi_flash_pkg::*; #(
	parameter int PW_CYCLES = PAGE_WRITE_CYCLES,
	parameter int PP_CYCLES = PAGE_PROGRAM_CYCLES
) (
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	spi_flash_if.flash LINK,
	output logic STANDBY_O,
	output logic BUSY_O
);
	typedef enum {C_IDLE, C_MERGE, C_ERASE, C_PROG, C_WAIT} cyc_e;

	logic [4:0] pin_meta_r;
	logic [4:0] pin_sync_r;
	logic sck_s, cs_s, din_s, rstpin_s, wp_s;
	logic sck_d_r, cs_d_r;
	logic rise, fall, cs_fall, cs_rise, hw_rst;
	logic sel_r;
	logic [2:0] bit_cnt_r;
	logic [2:0] byte_idx_r;
	logic [7:0] shift_r;
	logic [7:0] cmd_r;
	logic [23:0] addr_r;
	logic [MEM_AW-1:0] ptr_r;
	logic [MEM_AW-1:0] nxt_idx;
	logic [MEM_AW-1:0] rd_idx;
	logic [7:0] rx_byte;
	logic byte_done, is_page_cmd, take_data, load_stat, load_mem;
	logic [7:0] out_shift_r;
	logic dout_r, oe_r;
	logic [7:0] mem [MEM_BYTES];
	logic [7:0] page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] rx_mask_r;
	cyc_e cyc_st_r;
	logic [PAGE_AW-1:0] idx_r;
	logic [PAGE_SEL_W-1:0] page_r;
	logic [MEM_AW-1:0] cyc_addr;
	logic is_pw_r;
	logic [WAIT_W-1:0] wait_r;
	logic busy, start_cyc, cyc_done, whole_bytes;
	logic wel_r;
	logic [2:0] bp_r;
	logic [7:0] status;

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pin_meta_r <= PIN_IDLE;
			pin_sync_r <= PIN_IDLE;
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			pin_meta_r <= {LINK.sck, LINK.cs_n, LINK.mosi, LINK.rst_n, LINK.wp_n};
			pin_sync_r <= pin_meta_r;
			sck_d_r <= sck_s;
			cs_d_r <= cs_s;
		end
	end

	assign {sck_s, cs_s, din_s, rstpin_s, wp_s} = pin_sync_r;
	// Rising edge samples, falling edge shifts; idle level of the clock is irrelevant
	assign rise = sck_s & ~sck_d_r;
	assign fall = ~sck_s & sck_d_r;
	assign cs_fall = ~cs_s & cs_d_r;
	assign cs_rise = cs_s & ~cs_d_r;
	assign hw_rst = ~rstpin_s;
	assign busy = cyc_st_r != C_IDLE;
	assign rx_byte = {shift_r[6:0], din_s};
	assign byte_done = sel_r & rise & (bit_cnt_r == 3'h7);
	assign is_page_cmd = (cmd_r == CMD_PAGE_WRITE) || (cmd_r == CMD_PAGE_PROGRAM);
	assign take_data = byte_done && (byte_idx_r >= 3'h4) && is_page_cmd && !busy;
	assign load_stat = byte_done && (byte_idx_r == 3'h0 ? rx_byte == CMD_READ_STATUS : cmd_r == CMD_READ_STATUS);
	assign load_mem = byte_done && (cmd_r == CMD_READ_DATA) && (byte_idx_r >= 3'h3);
	assign nxt_idx = ptr_r + 1'b1;
	assign rd_idx = (byte_idx_r == 3'h3) ? {addr_r[PAGE_SEL_W-1:0], rx_byte} : nxt_idx;
	assign whole_bytes = sel_r && (bit_cnt_r == 3'h0);
	assign start_cyc = cs_rise && whole_bytes && is_page_cmd && (byte_idx_r >= 3'h5) && wel_r && !busy;
	assign cyc_addr = {page_r, idx_r};
	assign cyc_done = (cyc_st_r == C_WAIT) && (wait_r == '0);
	assign status = {3'h0, bp_r, wel_r, busy};

	// Transfer framing only begins at a seen falling edge of chip select
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sel_r <= 1'b0;
			bit_cnt_r <= 3'h0;
			byte_idx_r <= 3'h0;
			shift_r <= 8'h00;
			cmd_r <= 8'h00;
			addr_r <= 24'h000000;
			ptr_r <= '0;
		end else if (hw_rst || cs_rise) begin
			sel_r <= 1'b0;
		end else if (cs_fall) begin
			sel_r <= 1'b1;
			bit_cnt_r <= 3'h0;
			byte_idx_r <= 3'h0;
		end else if (sel_r && rise) begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r <= rx_byte;
			if (bit_cnt_r == 3'h7) begin
				if (byte_idx_r != 3'h7) begin
					byte_idx_r <= byte_idx_r + 3'h1;
				end
				if (byte_idx_r == 3'h0) begin
					cmd_r <= rx_byte;
				end else if (byte_idx_r <= 3'h3) begin
					addr_r <= {addr_r[15:0], rx_byte};
				end
				if (byte_idx_r == 3'h3) begin
					ptr_r <= {addr_r[PAGE_SEL_W-1:0], rx_byte};
				end else if (byte_idx_r >= 3'h4) begin
					if (cmd_r == CMD_READ_DATA) begin
						ptr_r <= nxt_idx;
					end else begin
						ptr_r <= {ptr_r[MEM_AW-1:PAGE_AW], ptr_r[PAGE_AW-1:0] + 8'h01};
					end
				end
			end
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			out_shift_r <= 8'h00;
			dout_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			oe_r <= ~cs_s & ~hw_rst;
			if (load_stat) begin
				out_shift_r <= status;
			end else if (load_mem) begin
				out_shift_r <= mem[rd_idx];
			end else if (sel_r && fall) begin
				dout_r <= out_shift_r[7];
				out_shift_r <= {out_shift_r[6:0], 1'b0};
			end
		end
	end

	assign LINK.miso_out = dout_r;
	assign LINK.miso_oe = oe_r;

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rx_mask_r <= '0;
		end else if (cs_fall && !busy) begin
			rx_mask_r <= '0;
		end else if (take_data) begin
			rx_mask_r[ptr_r[PAGE_AW-1:0]] <= 1'b1;
		end
	end

	// Program data of page program has untouched bytes at the erased value
	always_ff @(posedge CLOCK_I) begin
		if (take_data) begin
			page_buf[ptr_r[PAGE_AW-1:0]] <= rx_byte;
		end else if (cyc_st_r == C_MERGE && !rx_mask_r[idx_r]) begin
			page_buf[idx_r] <= is_pw_r ? mem[cyc_addr] : ERASED_BYTE;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (cyc_st_r == C_ERASE) begin
			mem[cyc_addr] <= ERASED_BYTE;
		end else if (cyc_st_r == C_PROG) begin
			mem[cyc_addr] <= mem[cyc_addr] & page_buf[idx_r];
		end
	end

	// A reset pin pulse aborts a running cycle; page content is then undefined
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cyc_st_r <= C_IDLE;
			idx_r <= '0;
			page_r <= '0;
			is_pw_r <= 1'b0;
			wait_r <= '0;
		end else if (hw_rst) begin
			cyc_st_r <= C_IDLE;
		end else begin
			case (cyc_st_r)
				C_IDLE: begin
					if (start_cyc) begin
						cyc_st_r <= C_MERGE;
						idx_r <= '0;
						page_r <= addr_r[PAGE_AW +: PAGE_SEL_W];
						is_pw_r <= cmd_r == CMD_PAGE_WRITE;
					end
				end
				C_MERGE: begin
					idx_r <= idx_r + 1'b1;
					if (idx_r == '1) begin
						cyc_st_r <= is_pw_r ? C_ERASE : C_PROG;
					end
				end
				C_ERASE: begin
					idx_r <= idx_r + 1'b1;
					if (idx_r == '1) begin
						cyc_st_r <= C_PROG;
					end
				end
				C_PROG: begin
					idx_r <= idx_r + 1'b1;
					if (idx_r == '1) begin
						cyc_st_r <= C_WAIT;
						wait_r <= is_pw_r ? WAIT_W'(PW_CYCLES - 1) : WAIT_W'(PP_CYCLES - 1);
					end
				end
				C_WAIT: begin
					wait_r <= wait_r - 1'b1;
					if (wait_r == '0) begin
						cyc_st_r <= C_IDLE;
					end
				end
				default: cyc_st_r <= C_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			wel_r <= 1'b0;
		end else if (hw_rst) begin
			wel_r <= 1'b0;
		end else begin
			if (cyc_done) begin
				wel_r <= 1'b0;
			end
			if (cs_rise && whole_bytes && byte_idx_r == 3'h1) begin
				if (cmd_r == CMD_WRITE_ENABLE) begin
					wel_r <= 1'b1;
				end else if (cmd_r == CMD_WRITE_DISABLE) begin
					wel_r <= 1'b0;
				end
			end
			if (cs_rise && whole_bytes && byte_idx_r == 3'h2 && cmd_r == CMD_WRITE_STATUS && !busy) begin
				wel_r <= 1'b0;
			end
		end
	end

	// Block protect bits are kept through a reset pin pulse
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			bp_r <= BP_RESET;
		end else if (cs_rise && whole_bytes && byte_idx_r == 3'h2 && cmd_r == CMD_WRITE_STATUS
			&& wel_r && wp_s && !busy && !hw_rst) begin
			bp_r <= shift_r[ST_BP_LSB +: 3];
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			STANDBY_O <= 1'b1;
			BUSY_O <= 1'b0;
		end else begin
			STANDBY_O <= cs_s && !busy;
			BUSY_O <= busy;
		end
	end
endmodule

// file: hw/spi_flash_host.sv
// Serial bus master for the flash: frames commands, address and data bytes
`timescale 1ns/1ns
module spi_flash_host import spi_flash_pkg::*; (
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	spi_flash_if.master LINK,
	input wire logic MODE3_I,
	input wire logic START_I,
	input wire logic [7:0] CMD_I,
	input wire logic [23:0] ADDR_I,
	input wire logic ADDR_EN_I,
	input wire logic [8:0] LEN_I,
	input wire logic [7:0] WDATA_I,
	input wire logic FLASH_RESET_N_I,
	input wire logic WP_N_I,
	output logic BUSY_O,
	output logic WDATA_TAKE_O,
	output logic [7:0] RDATA_O,
	output logic RDATA_VALID_O
);
	typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_GAP} host_e;

	host_e st_r;
	logic [HALF_W-1:0] cnt_r;
	logic tick;
	logic miso_meta_r, miso_s_r;
	logic sck_r, cs_n_r, mosi_r, rst_n_r, wp_n_r, cpol_r;
	logic [2:0] bit_cnt_r;
	logic [9:0] left_r;
	logic [2:0] hdr_r;
	logic [2:0] idx_r;
	logic [7:0] tx_r, rx_r, rxb, nb;
	logic [23:0] addr_r;
	logic [8:0] len;

	assign tick = cnt_r == HALF_W'(SCK_HALF_CYCLES - 1);
	assign rxb = {rx_r[6:0], miso_s_r};
	// Compare one bit wider: the byte index saturates at 7 and must not wrap back into the header
	assign nb = (({1'b0, idx_r} + 4'h1) < {1'b0, hdr_r}) ? addr_r[23:16] : WDATA_I;
	assign len = (LEN_I > 9'(MAX_DATA_BYTES)) ? 9'(MAX_DATA_BYTES) : LEN_I;

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			miso_meta_r <= 1'b1;
			miso_s_r <= 1'b1;
			rst_n_r <= 1'b0;
			wp_n_r <= 1'b0;
		end else begin
			miso_meta_r <= LINK.miso;
			miso_s_r <= miso_meta_r;
			rst_n_r <= FLASH_RESET_N_I;
			wp_n_r <= WP_N_I;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cnt_r <= '0;
		end else if (st_r == H_IDLE || tick) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			st_r <= H_IDLE;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			mosi_r <= 1'b0;
			cpol_r <= 1'b0;
			bit_cnt_r <= 3'h0;
			left_r <= '0;
			hdr_r <= 3'h1;
			idx_r <= 3'h0;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			addr_r <= 24'h000000;
			BUSY_O <= 1'b0;
			WDATA_TAKE_O <= 1'b0;
			RDATA_O <= 8'h00;
			RDATA_VALID_O <= 1'b0;
		end else begin
			WDATA_TAKE_O <= 1'b0;
			RDATA_VALID_O <= 1'b0;
			case (st_r)
				H_IDLE: begin
					sck_r <= MODE3_I;
					cpol_r <= MODE3_I;
					if (START_I) begin
						st_r <= H_SETUP;
						BUSY_O <= 1'b1;
						cs_n_r <= 1'b0;
						tx_r <= CMD_I;
						mosi_r <= CMD_I[7];
						addr_r <= ADDR_I;
						hdr_r <= ADDR_EN_I ? 3'h4 : 3'h1;
						left_r <= (ADDR_EN_I ? 10'h3 : 10'h0) + {1'b0, len};
						idx_r <= 3'h0;
						bit_cnt_r <= 3'h0;
					end
				end
				H_SETUP: begin
					if (tick) begin
						st_r <= H_LOW;
						sck_r <= 1'b0;
					end
				end
				H_LOW: begin
					if (tick) begin
						st_r <= H_HIGH;
						sck_r <= 1'b1;
					end
				end
				H_HIGH: begin
					if (tick) begin
						rx_r <= rxb;
						bit_cnt_r <= bit_cnt_r + 3'h1;
						if (bit_cnt_r != 3'h7) begin
							st_r <= H_LOW;
							sck_r <= 1'b0;
							tx_r <= {tx_r[6:0], 1'b0};
							mosi_r <= tx_r[6];
						end else begin
							if (idx_r >= hdr_r) begin
								RDATA_O <= rxb;
								RDATA_VALID_O <= 1'b1;
							end
							if (left_r != '0) begin
								left_r <= left_r - 1'b1;
								if (idx_r != 3'h7) begin
									idx_r <= idx_r + 3'h1;
								end
								if (({1'b0, idx_r} + 4'h1) < {1'b0, hdr_r}) begin
									addr_r <= {addr_r[15:0], 8'h00};
								end else begin
									WDATA_TAKE_O <= 1'b1;
								end
								tx_r <= nb;
								mosi_r <= nb[7];
								sck_r <= 1'b0;
								st_r <= H_LOW;
							end else begin
								sck_r <= cpol_r;
								st_r <= H_END;
							end
						end
					end
				end
				H_END: begin
					if (tick) begin
						cs_n_r <= 1'b1;
						st_r <= H_GAP;
					end
				end
				H_GAP: begin
					if (tick) begin
						BUSY_O <= 1'b0;
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	assign LINK.sck = sck_r;
	assign LINK.cs_n = cs_n_r;
	assign LINK.mosi = mosi_r;
	assign LINK.rst_n = rst_n_r;
	assign LINK.wp_n = wp_n_r;
endmodule

// file: bench/spi_flash_properties.sv
// Link checker for the flash slave and its bus master
`timescale 1ns/1ns
module spi_flash_properties (
	input wire logic CLOCK_I,
	input wire logic RSTN_I,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic rst_n,
	input wire logic miso_out,
	input wire logic miso_oe,
	input wire logic STANDBY_O,
	input wire logic BUSY_O
);
	logic sck_prev_r;
	logic idle_lvl_r;
	logic [3:0] since_fall_r;
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RSTN_I);
	// Cycles since the serial clock was seen falling
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sck_prev_r <= 1'b0;
			since_fall_r <= 4'hF;
		end else begin
			sck_prev_r <= sck;
			if (sck_prev_r && !sck) begin
				since_fall_r <= 4'h0;
			end else if (since_fall_r != 4'hF) begin
				since_fall_r <= since_fall_r + 4'h1;
			end
		end
	end
	// Clock level when the frame opened
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			idle_lvl_r <= 1'b0;
		end else if ($fell(cs_n)) begin
			idle_lvl_r <= sck;
		end
	end
	AST_OUT_AFTER_FALL: assert property (miso_oe && $past(miso_oe) && $changed(miso_out) |-> since_fall_r inside {[4'h1:4'h4]})
		else $error("output bit moved away from a clock fall");
	AST_DESELECT_RELEASE: assert property (cs_n [*4] |-> !miso_oe)
		else $error("output driven while deselected");
	AST_RESET_PIN_RELEASE: assert property (!rst_n [*3] |-> !miso_oe)
		else $error("output driven while reset pin low");
	AST_BUSY_NOT_STANDBY: assert property (BUSY_O && $past(BUSY_O) |-> !STANDBY_O)
		else $error("standby during internal cycle");
	AST_STANDBY_WHEN_IDLE: assert property ((cs_n && rst_n) [*4] ##0 !BUSY_O [*2] |-> STANDBY_O)
		else $error("no standby while idle and deselected");
	AST_SELECTED_ACTIVE: assert property (!cs_n [*4] |-> !STANDBY_O)
		else $error("standby while selected");
	AST_IDLE_LEVEL: assert property ($rose(cs_n) |-> sck == idle_lvl_r)
		else $error("clock idle level differs at frame end");
	AST_CYCLE_AFTER_DESELECT: assert property ($rose(BUSY_O) |-> cs_n && !$past(cs_n, 8))
		else $error("internal cycle began without a deselect");
	COV_PAGE_CYCLE: cover property ($rose(BUSY_O));
	COV_READ_OUT: cover property (miso_oe && $changed(miso_out));
	COV_RESET_PIN: cover property ($fell(rst_n) ##[1:20] $rose(rst_n));
endmodule

// file: bench/tb_serial_flash_spi_page_write.sv
// Bench: master and flash on one link, checked against a byte model
`timescale 1ns/1ns
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module tb_serial_flash_spi_page_write import spi_flash_pkg::*; ;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic mode3 = 1'b0;
	logic start = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic addr_en = 1'b0;
	logic [8:0] len = 9'h000;
	logic [7:0] wdata = 8'h00;
	logic frst_n = 1'b1;
	logic wp_n = 1'b1;
	logic hbusy;
	logic take;
	logic [7:0] rdata;
	logic rvalid;
	logic standby;
	logic dbusy;
	logic [7:0] mem [1024];
	logic [7:0] wq [$];
	logic [7:0] rq [$];
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	spi_flash_if link_if();
	spi_flash_host spi_flash_host_inst (.CLOCK_I(clock), .RSTN_I(rstn), .LINK(link_if.master), .MODE3_I(mode3),
		.START_I(start), .CMD_I(cmd), .ADDR_I(addr), .ADDR_EN_I(addr_en), .LEN_I(len), .WDATA_I(wdata),
		.FLASH_RESET_N_I(frst_n), .WP_N_I(wp_n), .BUSY_O(hbusy), .WDATA_TAKE_O(take), .RDATA_O(rdata),
		.RDATA_VALID_O(rvalid));
	spi_flash_dev #(.PW_CYCLES(20), .PP_CYCLES(20)) spi_flash_dev_inst (.CLOCK_I(clock), .RSTN_I(rstn),
		.LINK(link_if.flash), .STANDBY_O(standby), .BUSY_O(dbusy));
	spi_flash_properties spi_flash_properties_inst (.CLOCK_I(clock), .RSTN_I(rstn), .sck(link_if.sck),
		.cs_n(link_if.cs_n), .rst_n(link_if.rst_n), .miso_out(link_if.miso_out), .miso_oe(link_if.miso_oe),
		.STANDBY_O(standby), .BUSY_O(dbusy));
	always #50 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One framed transfer: bytes of wq go out, received bytes land in rq
	task automatic op(input logic [7:0] c, input logic [23:0] a, input logic ae, input int n);
		int i;
		i = 0;
		rq = {};
		@(negedge clock);
		cmd = c;
		addr = a;
		addr_en = ae;
		len = 9'(n);
		wdata = (wq.size() > 0) ? wq[0] : 8'h00;
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		for (int k = 0; k < 40000 && hbusy === 1'b1; k++) begin
			if (take === 1'b1) begin
				i++;
				wdata = (i < wq.size()) ? wq[i] : 8'h00;
			end
			if (rvalid === 1'b1) begin
				rq.push_back(rdata);
			end
			@(negedge clock);
		end
	endtask
	task automatic write_enable_cmd();
		wq = {};
		op(CMD_WRITE_ENABLE, 24'h000000, 1'b0, 0);
	endtask
	task automatic wr(input logic [7:0] c, input int a, input int n, input bit en);
		logic [7:0] d [$];
		d = {};
		repeat (n) d.push_back(8'($urandom));
		if (en) begin
			write_enable_cmd();
		end
		wq = d;
		op(c, 24'(a), 1'b1, n);
	endtask
	// Model of a page write or program; data wraps inside the page
	task automatic put(input int a, input bit prog);
		int x;
		foreach (wq[i]) begin
			x = (a & 32'h300) | ((a + i) & 32'hFF);
			mem[x] = prog ? (mem[x] & wq[i]) : wq[i];
		end
	endtask
	task automatic wait_dev();
		for (int k = 0; k < 3000 && dbusy !== 1'b0; k++) @(negedge clock);
		`CHK(dbusy, 1'b0)
	endtask
	task automatic st(input logic [7:0] m, input logic [7:0] e);
		wq = {};
		op(CMD_READ_STATUS, 24'h000000, 1'b0, 1);
		`CHK(rq[0] & m, e)
	endtask
	task automatic rd(input int a, input int n);
		wq = {};
		op(CMD_READ_DATA, 24'(a), 1'b1, n);
		for (int j = 0; j < n; j++) `CHK(rq[j], mem[a + j])
	endtask
	task automatic note(input string s);
		$display("test done: %s", s);
	endtask
	initial begin
		void'($urandom(32'h9886));
		repeat (4) @(posedge clock);
		@(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		wr(CMD_PAGE_WRITE, 10'h100, 256, 1);
		put(10'h100, 1'b0);
		wait_dev();
		rd(10'h100, 256);
		note("full page write");
		mode3 = 1'b1;
		wr(CMD_PAGE_WRITE, 10'h1F8, 16, 1);
		put(10'h1F8, 1'b0);
		wait_dev();
		rd(10'h100, 256);
		mode3 = 1'b0;
		note("partial write in mode 3");
		wr(CMD_PAGE_PROGRAM, 10'h140, 8, 1);
		put(10'h140, 1'b1);
		wait_dev();
		rd(10'h138, 24);
		note("page program");
		wr(CMD_PAGE_WRITE, 10'h100, 4, 0);
		repeat (20) @(negedge clock);
		st(8'hFF, 8'h00);
		rd(10'h100, 4);
		note("write without enable");
		wr(CMD_PAGE_WRITE, 10'h120, 1, 1);
		put(10'h120, 1'b0);
		st(8'hFF, 8'h03);
		wr(CMD_PAGE_WRITE, 10'h120, 1, 0);
		wait_dev();
		st(8'hFF, 8'h00);
		rd(10'h120, 1);
		note("busy cycle");
		write_enable_cmd();
		st(8'hFF, 8'h02);
		frst_n = 1'b0;
		repeat (10) @(negedge clock);
		frst_n = 1'b1;
		repeat (8) @(negedge clock);
		st(8'hFF, 8'h00);
		note("reset pin");
		wp_n = 1'b0;
		write_enable_cmd();
		wq = {8'h1C};
		op(CMD_WRITE_STATUS, 24'h000000, 1'b0, 1);
		wait_dev();
		st(8'h1C, 8'h00);
		wp_n = 1'b1;
		write_enable_cmd();
		wq = {8'h1C};
		op(CMD_WRITE_STATUS, 24'h000000, 1'b0, 1);
		wait_dev();
		st(8'h1C, 8'h1C);
		note("write protect");
		final_report();
	end
endmodule
